// >>> phy_datapath_mode_lane_router.sv
// Per-channel data path router: line/host mode selection, lane mapping and stage steering
//
// Implementation choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps

module phy_datapath_mode_lane_router #(
  parameter int W = 32
) (
  input  wire logic                                 clock,
  input  wire logic                                 rst_b,
  input  wire logic [lane_router_pkg::ADDR_W-1:0]   reg_addr,
  input  wire logic [31:0]                          reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [31:0]                          reg_rdata,
  input  wire logic [W-1:0]                         line_rx_data,
  input  wire logic                                 line_rx_valid,
  output logic                                      line_rx_ready,
  input  wire logic [W-1:0]                         peer_rx_data,
  input  wire logic                                 peer_rx_valid,
  output logic                                      peer_rx_ready,
  output logic      [3:0][W/4-1:0]                  host_tx_data,
  output logic      [3:0]                           host_tx_lane_en,
  output logic                                      host_tx_valid,
  input  wire logic                                 host_tx_ready,
  input  wire logic [3:0][W/4-1:0]                  host_rx_data,
  input  wire logic                                 host_rx_valid,
  output logic      [W-1:0]                         line_tx_data,
  output logic                                      line_tx_valid,
  output lane_router_pkg::path_t                    path,
  output logic      [1:0]                           line_rate
);
  import lane_router_pkg::*;

  localparam int LW = W / 4;

  // Configuration and reinitialisation state
  cfg_t              cfg_q;
  logic [7:0]        reinit_q;
  logic [7:0]        reinit_d;
  path_t             path_d;
  logic [1:0]        rate_d;

  // Ingress two-entry buffer
  logic [1:0][W-1:0] mem_q;
  logic              wp_q;
  logic              rp_q;
  logic [1:0]        cnt_q;
  logic [1:0]        cnt_d;
  logic              src_rdy_q;

  // Ingress serializer toward the host lanes
  logic [W-1:0]      word_q;
  logic [W-1:0]      word_d;
  logic [1:0]        beat_q;
  logic [1:0]        beat_d;
  logic              txv_d;
  logic [3:0][LW-1:0] lane_d;
  logic [3:0]        lane_en_d;

  // Egress gather from the host lanes
  logic [3:0][LW-1:0] acc_q;
  logic [3:0][LW-1:0] acc_d;
  logic [1:0]        gbeat_q;
  logic [3:0][2:0]   gmap;

  // Register decode; STATUS is read-only, so writes to it and to unmapped addresses are dropped
  wire        hit_cfg    = reg_addr == CFG_ADDR;
  wire        hit_status = reg_addr == STATUS_ADDR;
  wire cfg_t  cfg_w      = cfg_t'(reg_wdata[7:0]);
  wire        cfg_wr     = reg_wr && hit_cfg;
  // Static fields changing, or the ingress source switching, restarts the path
  wire [4:0]  static_w   = {cfg_w.mode, cfg_w.rxaui, cfg_w.lane3, cfg_w.xconn};
  wire [4:0]  static_q   = {cfg_q.mode, cfg_q.rxaui, cfg_q.lane3, cfg_q.xconn};
  wire        restart    = cfg_wr && (static_w != static_q);
  wire        busy       = reinit_q != 8'h00;
  wire        is_gbe     = cfg_q.mode == MODE_GBE;
  wire        is_wan     = cfg_q.mode == MODE_WAN;
  wire [1:0]  last_beat  = is_gbe ? LAST_GBE : (cfg_q.rxaui ? LAST_RXAUI : LAST_XAUI);
  wire [1:0]  gbe_lane   = cfg_q.lane3 ? LANE_ALT : LANE_A;

  // Cross connect picks the ingress source; egress only ever reaches the own PMA
  wire [W-1:0] src_data  = cfg_q.xconn ? peer_rx_data : line_rx_data;
  wire         src_valid = cfg_q.xconn ? peer_rx_valid : line_rx_valid;
  wire         push      = src_valid && src_rdy_q && !busy;
  wire         last_out  = beat_q == last_beat;
  wire         beat_take = host_tx_valid && host_tx_ready;
  wire         drain     = !host_tx_valid || (beat_take && last_out);
  wire         pop       = (cnt_q != 2'h0) && drain && !busy;
  wire         gath_last = gbeat_q == last_beat;

  // Chunk carried by a lane at a given beat: {enable, chunk index}
  // The configuration comes in as arguments so every caller follows a mode change
  function automatic logic [2:0] lane_map(
    input logic [1:0] lane,
    input logic [1:0] beat,
    input logic       gbe,
    input logic       two_lane,
    input logic [1:0] sel_lane
  );
    logic [2:0] r;
    r = 3'h0;
    if (gbe) begin
      if (lane == sel_lane) r = {1'b1, beat};
    end else if (two_lane) begin
      if (lane == LANE_A) r = {1'b1, beat[0], 1'b0};
      else if (lane == LANE_B) r = {1'b1, beat[0], 1'b1};
    end else begin
      r = {1'b1, lane};
    end
    return r;
  endfunction

  // Stages on the path follow the mode and the stage enables; MACs need security in 10G
  // With the MACs out, the rate FIFO covers the host/line rate gap instead
  always_comb begin
    path_d         = PATH_RESET;
    path_d.busy    = busy || restart;
    path_d.wis_rx  = is_wan;
    path_d.wis_tx  = is_wan;
    path_d.pcs10   = !is_gbe;
    path_d.xgxs    = !is_gbe;
    path_d.pcs1g_l = is_gbe;
    path_d.pcs1g_h = is_gbe;
    path_d.ts      = cfg_q.ts_en;
    path_d.sec     = cfg_q.sec_en;
    path_d.mac     = cfg_q.mac_en && (is_gbe || cfg_q.sec_en);
    path_d.fc_buf  = path_d.mac;
    rate_d         = is_gbe ? RATE_GBE : (is_wan ? RATE_WAN : RATE_LAN);
  end

  // Configuration register and reinitialisation counter
  // A write that only flips stage enables keeps traffic flowing
  assign reinit_d = restart ? 8'(REINIT_CYC) : (busy ? reinit_q - 8'h01 : 8'h00);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      cfg_q    <= CFG_RESET;
      reinit_q <= 8'(REINIT_CYC);
    end else begin
      if (cfg_wr) cfg_q <= cfg_w;
      reinit_q <= reinit_d;
    end
  end

  // Readable words
  wire [31:0] cfg_word    = {24'h0, cfg_q};
  wire [31:0] status_word = {16'h0, cnt_q, line_rate, 1'b0, path};

  // Read data stands in the cycle after the read strobe only
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      reg_rdata <= 32'h0;
    end else if (reg_rd && hit_cfg) begin
      reg_rdata <= cfg_word;
    end else if (reg_rd && hit_status) begin
      reg_rdata <= status_word;
    end else begin
      reg_rdata <= 32'h0;
    end
  end

  // Path and rate status
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      path      <= PATH_RESET;
      line_rate <= RATE_LAN;
    end else begin
      path      <= path_d;
      line_rate <= rate_d;
    end
  end

  // Ingress buffer: flushed while the path restarts; ready back-pressure means a stall never drops a word
  // Pointers restart at zero so a flushed path starts clean
  assign cnt_d = (busy || restart) ? 2'h0 : 2'(cnt_q + {1'b0, push} - {1'b0, pop});
  wire   can_take = !busy && !restart && (cnt_d != 2'h2);

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      mem_q     <= '0;
      wp_q      <= 1'b0;
      rp_q      <= 1'b0;
      cnt_q     <= 2'h0;
      src_rdy_q <= 1'b0;
    end else begin
      if (push) mem_q[wp_q] <= src_data;
      wp_q      <= (busy || restart) ? 1'b0 : wp_q ^ push;
      rp_q      <= (busy || restart) ? 1'b0 : rp_q ^ pop;
      cnt_q     <= cnt_d;
      src_rdy_q <= can_take;
    end
  end

  // Ready goes only to the source the cross connect has selected
  // Ready follows the next count, so a word taken while ready falls still has room
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      line_rx_ready <= 1'b0;
      peer_rx_ready <= 1'b0;
    end else begin
      line_rx_ready <= can_take && !cfg_q.xconn;
      peer_rx_ready <= can_take && cfg_q.xconn;
    end
  end

  // Serializer next state: load a word, or step through its beats
  always_comb begin
    word_d = word_q;
    beat_d = beat_q;
    txv_d  = host_tx_valid;
    if (busy || restart) begin
      txv_d  = 1'b0;
      beat_d = 2'h0;
    end else if (pop) begin
      word_d = mem_q[rp_q];
      beat_d = 2'h0;
      txv_d  = 1'b1;
    end else if (beat_take) begin
      if (last_out) txv_d = 1'b0;
      else beat_d = beat_q + 2'h1;
    end
  end

  // Lane contents for the next beat; unused lanes are quiet
  // so the host never mistakes a stale chunk for data
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_tx_lane
    wire [2:0] m = lane_map(2'(l), beat_d, is_gbe, cfg_q.rxaui, gbe_lane);
    // Chunk this lane carries at the current egress gather beat
    assign gmap[l]      = lane_map(2'(l), gbeat_q, is_gbe, cfg_q.rxaui, gbe_lane);
    assign lane_en_d[l] = m[2] && txv_d;
    assign lane_d[l]    = lane_en_d[l] ? word_d[m[1:0]*LW +: LW] : '0;
  end

  always_ff @(posedge clock) begin
    if (!rst_b) begin
      word_q          <= '0;
      beat_q          <= 2'h0;
      host_tx_valid   <= 1'b0;
      host_tx_data    <= '0;
      host_tx_lane_en <= 4'h0;
    end else begin
      word_q          <= word_d;
      beat_q          <= beat_d;
      host_tx_valid   <= txv_d;
      host_tx_data    <= lane_d;
      host_tx_lane_en <= lane_en_d;
    end
  end

  // Egress gather: each active lane fills its chunk of the line word
  always_comb begin
    acc_d = acc_q;
    for (int l = 0; l < NUM_LANES; l++) begin
      if (gmap[l][2]) begin
        acc_d[gmap[l][1:0]] = host_rx_data[l];
      end
    end
  end

  // Completed words go to the own PMA only
  // Beats that arrive while the path restarts are dropped and the gather starts over
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      acc_q         <= '0;
      gbeat_q       <= 2'h0;
      line_tx_data  <= '0;
      line_tx_valid <= 1'b0;
    end else if (busy || restart) begin
      gbeat_q       <= 2'h0;
      line_tx_valid <= 1'b0;
    end else if (host_rx_valid) begin
      acc_q         <= acc_d;
      gbeat_q       <= gath_last ? 2'h0 : gbeat_q + 2'h1;
      line_tx_valid <= gath_last;
      if (gath_last) line_tx_data <= acc_d;
    end else begin
      line_tx_valid <= 1'b0;
    end
  end

endmodule // phy_datapath_mode_lane_router

// >>> lane_router_pkg.sv
// Package: constants, register layout and carrier types for the lane router
package lane_router_pkg;

  // Register map, word aligned
  localparam int               ADDR_W      = 8;
  localparam logic [7:0]       CFG_ADDR    = 8'h00;
  localparam logic [7:0]       STATUS_ADDR = 8'h04;

  // Operating mode encodings of the mode field
  localparam logic [1:0]       MODE_LAN    = 2'h0;
  localparam logic [1:0]       MODE_WAN    = 2'h1;
  localparam logic [1:0]       MODE_GBE    = 2'h2;

  // Line rate codes shown in status
  localparam logic [1:0]       RATE_LAN    = 2'h0;  // 10.3125 Gbps 64b/66b
  localparam logic [1:0]       RATE_WAN    = 2'h1;  // 9.953 Gbps STS-192c
  localparam logic [1:0]       RATE_GBE    = 2'h2;  // 1.25 Gbps 8b/10b

  // Host lane positions
  localparam int               NUM_LANES   = 4;
  localparam logic [1:0]       LANE_A      = 2'h0;  // RXAUI first lane, 1G default lane
  localparam logic [1:0]       LANE_B      = 2'h2;  // RXAUI second lane
  localparam logic [1:0]       LANE_ALT    = 2'h3;  // 1G alternate lane

  // Index of the last beat of a data word on the host side
  localparam logic [1:0]       LAST_XAUI   = 2'h0;
  localparam logic [1:0]       LAST_RXAUI  = 2'h1;
  localparam logic [1:0]       LAST_GBE    = 2'h3;

  // Reinitialisation hold time after a configuration change
  localparam int               REINIT_NS     = 160;
  localparam int               CLK_PERIOD_NS = 10;
  localparam int               REINIT_CYC    = (REINIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Configuration register layout, bits 7:0 of the config word
  typedef struct packed {
    logic       xconn;   // Take ingress from the peer port's PMA
    logic       mac_en;  // MAC stages requested
    logic       sec_en;  // Security stage requested
    logic       ts_en;   // Timestamping stage requested
    logic       lane3;   // 1G host lane on position 3 instead of 0
    logic       rxaui;   // Two-lane host interface
    logic [1:0] mode;    // Line-side operating mode
  } cfg_t;

  localparam cfg_t CFG_RESET = '{default: 1'b0};

  // Stages on the active path, bits 10:0 of the status word
  typedef struct packed {
    logic fc_buf;    // Flow control buffer does rate compensation, else rate FIFO
    logic mac;       // MAC stages in path
    logic sec;       // Security stage in path
    logic ts;        // Timestamping stage in path
    logic xgxs;      // 10G host coding and lane alignment
    logic pcs1g_h;   // Host-side 1G PCS
    logic pcs1g_l;   // Line-side 1G PCS
    logic pcs10;     // 10G PCS
    logic wis_tx;    // WAN sublayer, transmit direction
    logic wis_rx;    // WAN sublayer, receive direction
    logic busy;      // Data path held in reinitialisation
  } path_t;

  localparam path_t PATH_RESET = '{default: 1'b0};

endpackage

// >>> lane_router_checker.sv
// Concurrent checks on the lane router ports
`timescale 1ns/1ps

module lane_router_checker #(
  parameter int W = 32
) (
  input wire logic                   clock,
  input wire logic                   rst_b,
  input wire logic [3:0][W/4-1:0]    host_tx_data,
  input wire logic [3:0]             host_tx_lane_en,
  input wire logic                   host_tx_valid,
  input wire logic                   host_tx_ready,
  input wire logic                   line_rx_ready,
  input wire logic                   peer_rx_ready,
  input wire lane_router_pkg::path_t path,
  input wire logic [1:0]             line_rate
);
  import lane_router_pkg::*;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic [5:0] busy_cnt_q;

  // Length of the current reinitialisation hold
  always_ff @(posedge clock) begin
    if (!rst_b) busy_cnt_q <= 6'h00;
    else busy_cnt_q <= path.busy ? busy_cnt_q + 6'h01 : 6'h00;
  end

  AST_WIS_BOTH: assert property (path.wis_rx == path.wis_tx) else $error("wan split");
  AST_WAN_RATE: assert property (path.wis_rx |-> line_rate == RATE_WAN && path.pcs10)
    else $error("wan path");
  AST_GBE_PCS: assert property (path.pcs1g_l |-> path.pcs1g_h && !path.pcs10 && line_rate == RATE_GBE)
    else $error("1g path");
  AST_MAC_SEC: assert property (path.mac && path.pcs10 |-> path.sec) else $error("mac alone");
  AST_FC_BUF: assert property (path.fc_buf == path.mac) else $error("rate buffer");
  AST_LANES_10G: assert property (host_tx_valid && path.xgxs |-> host_tx_lane_en inside {4'hf, 4'h5})
    else $error("10g lanes");
  AST_LANES_1G: assert property (host_tx_valid && path.pcs1g_h |-> host_tx_lane_en inside {4'h1, 4'h8})
    else $error("1g lane");
  AST_RXAUI_IDLE: assert property (host_tx_valid && host_tx_lane_en == 4'h5 |->
    host_tx_data[1] == '0 && host_tx_data[3] == '0) else $error("unused lane");
  AST_BEAT_HOLD: assert property (host_tx_valid && !host_tx_ready && !path.busy |=>
    path.busy || (host_tx_valid && $stable(host_tx_data))) else $error("beat lost");
  AST_XCONN_ONE: assert property (!(line_rx_ready && peer_rx_ready)) else $error("two sources");
  AST_BUSY_LEN: assert property ($fell(path.busy) |-> busy_cnt_q inside {[REINIT_CYC-1:REINIT_CYC+1]})
    else $error("reinit length");

  // Main scenarios reached
  COV_RXAUI: cover property (host_tx_valid && host_tx_lane_en == 4'h5);
  COV_LANE3: cover property (host_tx_valid && host_tx_lane_en == 4'h8);
  COV_PEER: cover property (peer_rx_ready);
  COV_REINIT: cover property ($fell(path.busy));
endmodule // lane_router_checker

bind phy_datapath_mode_lane_router lane_router_checker #(.W(W)) i_chk (.clock, .rst_b, .host_tx_data,
  .host_tx_lane_en, .host_tx_valid, .host_tx_ready, .line_rx_ready, .peer_rx_ready, .path, .line_rate);

// >>> host_far_end.sv
// Behavioural host switch: accepts beats with random stalls and sends host beats
`timescale 1ns/1ps

module host_far_end #(
  parameter int W = 32
) (
  input  wire logic                  clock,
  input  wire logic                  rst_b,
  input  wire logic                  hold,
  input  wire lane_router_pkg::cfg_t cfg,
  input  wire logic                  go,
  input  wire logic [W-1:0]          word,
  output logic                       host_tx_ready,
  output logic      [3:0][W/4-1:0]   host_rx_data,
  output logic                       host_rx_valid
);
  import lane_router_pkg::*;
  localparam int CW = W / 4;
  logic [1:0]   b_q;
  logic         act_q;
  logic [W-1:0] w_q;
  wire  [1:0]   last = cfg.mode == MODE_GBE ? 2'h3 : {1'b0, cfg.rxaui};
  wire  [1:0]   lane = cfg.lane3 ? LANE_ALT : LANE_A;

  initial begin
    host_tx_ready = 1'b0;
    host_rx_data = '0;
    host_rx_valid = 1'b0;
  end

  // Undriven lanes toggle so stale data never looks valid
  always @(posedge clock) begin
    host_tx_ready <= rst_b && !hold && ($urandom % 4 != 0);
    host_rx_valid <= act_q;
    for (int l = 0; l < 4; l++) host_rx_data[l] <= ~host_rx_data[l];
    if (act_q && cfg.mode == MODE_GBE) host_rx_data[lane] <= w_q[CW*b_q +: CW];
    else if (act_q && cfg.rxaui) begin
      host_rx_data[LANE_A] <= w_q[2*CW*b_q +: CW];
      host_rx_data[LANE_B] <= w_q[2*CW*b_q+CW +: CW];
    end else if (act_q) host_rx_data <= w_q;
    if (!rst_b) act_q <= 1'b0;
    else if (go) begin
      w_q <= word;
      act_q <= 1'b1;
      b_q <= 2'h0;
    end else if (act_q) begin
      b_q <= b_q + 2'h1;
      act_q <= b_q != last;
    end
  end
endmodule // host_far_end

// >>> tb.sv
// Self-checking bench for the lane router
`timescale 1ns/1ps

module tb;
  import lane_router_pkg::*;
  logic clock = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, hold = 0, go = 0;
  logic line_rx_valid = 0, peer_rx_valid = 0, host_tx_ready, host_rx_valid;
  logic line_rx_ready, peer_rx_ready, host_tx_valid, line_tx_valid;
  logic [7:0]       reg_addr = 0;
  logic [31:0]      reg_wdata = 0, reg_rdata, line_rx_data = 0, peer_rx_data = 0, line_tx_data, word = 0, v, acc;
  logic [3:0][7:0]  host_tx_data, host_rx_data;
  logic [3:0]       host_tx_lane_en;
  logic [1:0]       line_rate;
  path_t            path;
  cfg_t             cur;
  int               bad_count = 0, checks = 0, bi = 0;
  logic [31:0]      exp_in[$], exp_out[$];
  logic [7:0]       tbl[8] = '{8'h01, 8'h04, 8'h05, 8'h02, 8'h0a, 8'h80, 8'h8a, 8'h00};

  always #5 clock = ~clock;

  phy_datapath_mode_lane_router i_dut (.clock, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .line_rx_data, .line_rx_valid, .line_rx_ready, .peer_rx_data, .peer_rx_valid, .peer_rx_ready, .host_tx_data,
    .host_tx_lane_en, .host_tx_valid, .host_tx_ready, .host_rx_data, .host_rx_valid, .line_tx_data,
    .line_tx_valid, .path, .line_rate);
  host_far_end i_far (.clock, .rst_b, .hold, .cfg(cur), .go, .word, .host_tx_ready, .host_rx_data, .host_rx_valid);

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic conclude;
    $display("checks %0d bad_count %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  function automatic path_t xp(input cfg_t c);
    logic g, w, m;
    g = c.mode == MODE_GBE;
    w = c.mode == MODE_WAN;
    m = c.mac_en & (g | c.sec_en);
    xp = '{fc_buf: m, mac: m, sec: c.sec_en, ts: c.ts_en, xgxs: !g, pcs1g_h: g, pcs1g_l: g, pcs10: !g,
           wis_tx: w, wis_rx: w, busy: 1'b0};
  endfunction

  // Line rate code expected for a configuration
  function automatic logic [1:0] xr(input cfg_t c);
    xr = c.mode == MODE_WAN ? RATE_WAN : (c.mode == MODE_GBE ? RATE_GBE : RATE_LAN);
  endfunction

  // Register bus cycles, read data taken in the cycle after the strobe
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clock);
    {reg_rd, reg_addr} <= {1'b1, a};
    @(posedge clock);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic settle;
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (path.busy !== 1'b0 && n < 60);
    exp_in.delete();
    exp_out.delete();
    bi = 0;
  endtask

  // Ingress word held until taken at an edge with ready high
  task automatic push(input logic [31:0] w, input logic last);
    int n;
    {line_rx_valid, peer_rx_valid, line_rx_data, peer_rx_data} <= {1'b1, cur.xconn, cur.xconn ? ~w : w, w};
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while ((cur.xconn ? peer_rx_ready : line_rx_ready) !== 1'b1 && n < 200);
    @(posedge clock);
    exp_in.push_back(w);
    if (last) {line_rx_valid, peer_rx_valid} <= 2'b00;
  endtask

  // Reassemble host beats into words
  always @(posedge clock) begin
    if (rst_b && host_tx_valid === 1'b1 && host_tx_ready === 1'b1) begin
      if (cur.mode == MODE_GBE) begin
        chk(host_tx_lane_en, cur.lane3 ? 4'h8 : 4'h1);
        acc[8*bi +: 8] = host_tx_data[cur.lane3 ? 3 : 0];
      end else if (cur.rxaui) begin
        chk(host_tx_lane_en, 4'h5);
        acc[16*bi +: 16] = {host_tx_data[2], host_tx_data[0]};
      end else begin
        chk(host_tx_lane_en, 4'hf);
        acc = host_tx_data;
      end
      bi++;
      if (bi == (cur.mode == MODE_GBE ? 4 : cur.rxaui ? 2 : 1)) begin
        chk(acc, exp_in.size() ? exp_in.pop_front() : ~acc);
        bi = 0;
      end
    end
    if (rst_b && line_tx_valid === 1'b1) chk(line_tx_data, exp_out.size() ? exp_out.pop_front() : ~line_tx_data);
  end

  initial begin
    cur = CFG_RESET;
    void'($urandom(17));
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    rd(CFG_ADDR, v);
    chk(v, 32'h0);
    settle();
    wr(STATUS_ADDR, 32'hffffffff);
    rd(8'h08, v);
    chk(v, 32'h0);
    for (int i = 0; i < 8; i++) begin
      cur = cfg_t'(tbl[i] | (8'($urandom) & 8'h70));
      wr(CFG_ADDR, {24'h0, cur});
      repeat (2) @(negedge clock);
      chk(path.busy, 1'b1);
      settle();
      chk(path, xp(cur));
      chk(line_rate, xr(cur));
      chk({line_rx_ready, peer_rx_ready}, {!cur.xconn, cur.xconn});
      rd(STATUS_ADDR, v);
      chk(v & 32'hffff3fff, {18'h0, xr(cur), 1'b0, xp(cur)});
      @(posedge clock);
      hold <= i == 3;
      if (i == 3) fork
        begin
          repeat (30) @(negedge clock);
          chk(line_rx_ready, 1'b0);
          hold <= 1'b0;
        end
      join_none
      for (int k = 0; k < 6; k++) push($urandom, k == 5);
      for (int k = 0; k < 3; k++) begin
        @(posedge clock);
        {go, word} <= {1'b1, 32'($urandom)};
        @(posedge clock);
        exp_out.push_back(word);
        go <= 1'b0;
        repeat (5) @(posedge clock);
      end
      repeat (40) @(posedge clock);
      chk(exp_in.size() + exp_out.size(), 0);
    end
    cur.sec_en = !cur.sec_en;
    wr(CFG_ADDR, {24'h0, cur});
    repeat (2) @(negedge clock);
    chk(path, xp(cur));
    conclude();
  end

  initial begin
    #300000;
    bad_count++;
    conclude();
  end
endmodule // tb
